//--- hdl/rss_pkg.sv
// Shared constants and types of the rotate, subtract and skip datapath.
// Assumes an 8-bit data path and a 2-bit register port address.
package rss_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  localparam int BIT_SEL_W = 3;
  localparam int SKIP_CNT_W = 8;

  // Register port offsets
  localparam logic [1:0] REG_WREG = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_SKIP_COUNT = 2'h2;
  localparam logic [1:0] REG_LAST_RESULT = 2'h3;

  // Status register bit positions
  localparam int ST_CARRY_BIT = 0;
  localparam int ST_HALF_CARRY_BIT = 1;
  localparam int ST_ZERO_BIT = 2;
  localparam int ST_SIGNED_WRAP_BIT = 3;
  localparam int ST_USED_W = 4;

  // Reset values
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] SKIP_COUNT_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;

  // Operand constants
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ALL_ZEROS = 8'h00;
  localparam logic [7:0] BIT0_MASK = 8'h01;

  // Cycle counts of an instruction
  localparam int CYCLES_PLAIN = 1;
  localparam int CYCLES_SKIPPED = 2;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_ROTATE_LEFT_THROUGH_CARRY,
    OP_ROTATE_LEFT_CARRY_TO_WREG,
    OP_ROTATE_RIGHT_PLAIN,
    OP_ROTATE_RIGHT_TO_WREG,
    OP_ROTATE_RIGHT_THROUGH_CARRY,
    OP_ROTATE_RIGHT_CARRY_TO_WREG,
    OP_MINUS_WITH_BORROW,
    OP_MINUS_BORROW_TO_MEMORY,
    OP_MINUS,
    OP_MINUS_TO_MEMORY,
    OP_MINUS_IMMEDIATE,
    OP_DECREMENT_SKIP_ZERO,
    OP_DECREMENT_SKIP_ZERO_TO_WREG,
    OP_SET_BYTE,
    OP_SET_BIT,
    OP_INCREMENT_SKIP_ZERO,
    OP_INCREMENT_SKIP_ZERO_TO_WREG,
    OP_BIT_SET_SKIP,
    OP_NIBBLE_EXCHANGE,
    OP_NIBBLE_EXCHANGE_TO_WREG
  } rss_op_type;

  typedef enum logic {
    ST_EXECUTE,
    ST_DUMMY
  } rss_state_type;

endpackage

//--- hdl/rss_adder.sv
// Carry-in adder with nibble carry, signed wrap and zero detection.
// Assumes the caller inverts the subtrahend itself when it subtracts.
`timescale 1ns/100ps
module rss_adder #(
  parameter int WIDTH = 8
) (
  // Operands
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic cin,
  // Results
  output logic [WIDTH-1:0] sum,
  output logic cout,
  output logic hcout,
  output logic ovf,
  output logic zero
);

  localparam int HALF = WIDTH / 2;

  logic [WIDTH:0] full;
  logic [HALF:0] low;

  assign full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
  assign low = {1'b0, a[HALF-1:0]} + {1'b0, b[HALF-1:0]} + {{HALF{1'b0}}, cin};
  assign sum = full[WIDTH-1:0];
  assign cout = full[WIDTH];
  assign hcout = low[HALF];
  // Both operands of one sign giving a sum of the other sign
  assign ovf = (a[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
  assign zero = (sum == {WIDTH{1'b0}});

endmodule

//--- hdl/rss_datapath.sv
// Rotate, subtract, count-and-skip, set and swap part of an 8-bit core.
// Assumes the core presents one operation with its fetched memory byte,
// and writes mem_wdata back to the same address when mem_we pulses.
`timescale 1ns/100ps
module rss_datapath #(
  parameter int DATA_W = rss_pkg::DATA_W
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Operation issue
  input wire logic op_valid,
  input wire rss_pkg::rss_op_type op_code,
  input wire logic [rss_pkg::BIT_SEL_W-1:0] bit_sel,
  input wire logic [DATA_W-1:0] imm_data,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic op_ready,
  // Memory write back
  output logic mem_we,
  output logic [DATA_W-1:0] mem_wdata,
  // Prefetch discard
  output logic skip_pulse,
  // Architectural state
  output logic [DATA_W-1:0] working_register,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  output logic signed_wrap_flag,
  // Register port
  input wire logic [rss_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata
);

  // State
  rss_pkg::rss_state_type state_r;
  rss_pkg::rss_state_type state_nxt;
  logic [DATA_W-1:0] wreg_r;
  logic [DATA_W-1:0] wreg_nxt;
  logic carry_r;
  logic carry_nxt;
  logic half_carry_r;
  logic half_carry_nxt;
  logic zero_r;
  logic zero_nxt;
  logic signed_wrap_r;
  logic signed_wrap_nxt;
  logic mem_we_r;
  logic [DATA_W-1:0] mem_wdata_r;
  logic skip_r;
  logic ready_r;
  logic [DATA_W-1:0] reg_rdata_r;
  logic [DATA_W-1:0] reg_rdata_nxt;
  logic [rss_pkg::SKIP_CNT_W-1:0] skip_count_r;
  logic [DATA_W-1:0] last_result_r;

  // Operation decode
  logic [DATA_W-1:0] result;
  logic to_mem;
  logic to_wreg;
  logic upd_carry;
  logic new_carry;
  logic upd_arith;
  logic skip_cond;

  // Shared datapath terms
  // A request in the dummy cycle is dropped, not queued; the core presents it again
  wire op_take = clk_en && op_valid && (state_r == rss_pkg::ST_EXECUTE);
  wire [DATA_W-1:0] bit_mask = rss_pkg::BIT0_MASK << bit_sel;
  wire bit_chosen = mem_rdata[bit_sel];
  wire [DATA_W-1:0] rot_left_carry = {mem_rdata[DATA_W-2:0], carry_r};
  wire [DATA_W-1:0] rot_right_plain = {mem_rdata[0], mem_rdata[DATA_W-1:1]};
  wire [DATA_W-1:0] rot_right_carry = {carry_r, mem_rdata[DATA_W-1:1]};
  wire [DATA_W-1:0] nibble_swapped = {mem_rdata[DATA_W/2-1:0], mem_rdata[DATA_W-1:DATA_W/2]};
  wire [DATA_W-1:0] bit_forced = mem_rdata | bit_mask;

  // Subtractor operand selection
  wire sub_imm = (op_code == rss_pkg::OP_MINUS_IMMEDIATE);
  wire sub_borrow = (op_code == rss_pkg::OP_MINUS_WITH_BORROW)
                 || (op_code == rss_pkg::OP_MINUS_BORROW_TO_MEMORY);
  wire [DATA_W-1:0] sub_subtrahend = sub_imm ? imm_data : mem_rdata;
  // Borrow variants add the stored carry; plain ones add one
  wire sub_cin = sub_borrow ? carry_r : 1'b1;
  wire [DATA_W-1:0] sub_sum;
  wire sub_cout;
  wire sub_hcout;
  wire sub_ovf;
  wire sub_zero;

  rss_adder #(
    .WIDTH(DATA_W)
  ) u_subtract (
    .a(wreg_r),
    .b(~sub_subtrahend),
    .cin(sub_cin),
    .sum(sub_sum),
    .cout(sub_cout),
    .hcout(sub_hcout),
    .ovf(sub_ovf),
    .zero(sub_zero)
  );

  // Counter step: adding all ones decrements, adding one increments
  // Its own adder keeps the skip test off the subtractor's carry path
  wire step_up = (op_code == rss_pkg::OP_INCREMENT_SKIP_ZERO)
              || (op_code == rss_pkg::OP_INCREMENT_SKIP_ZERO_TO_WREG);
  wire [DATA_W-1:0] step_b = step_up ? rss_pkg::ALL_ZEROS : rss_pkg::ALL_ONES;
  wire [DATA_W-1:0] step_sum;
  wire step_zero;

  rss_adder #(
    .WIDTH(DATA_W)
  ) u_step (
    .a(mem_rdata),
    .b(step_b),
    .cin(step_up),
    .sum(step_sum),
    .cout(),
    .hcout(),
    .ovf(),
    .zero(step_zero)
  );

  // Per-operation result, destination and flag effects
  always_comb begin
    result = mem_rdata;
    to_mem = 1'b0;
    to_wreg = 1'b0;
    upd_carry = 1'b0;
    new_carry = carry_r;
    upd_arith = 1'b0;
    skip_cond = 1'b0;
    unique case (op_code)
      rss_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
        result = rot_left_carry;
        to_mem = 1'b1;
        upd_carry = 1'b1;
        new_carry = mem_rdata[DATA_W-1];
      end
      rss_pkg::OP_ROTATE_LEFT_CARRY_TO_WREG: begin
        result = rot_left_carry;
        to_wreg = 1'b1;
        upd_carry = 1'b1;
        new_carry = mem_rdata[DATA_W-1];
      end
      rss_pkg::OP_ROTATE_RIGHT_PLAIN: begin
        result = rot_right_plain;
        to_mem = 1'b1;
      end
      rss_pkg::OP_ROTATE_RIGHT_TO_WREG: begin
        result = rot_right_plain;
        to_wreg = 1'b1;
      end
      rss_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        result = rot_right_carry;
        to_mem = 1'b1;
        upd_carry = 1'b1;
        new_carry = mem_rdata[0];
      end
      rss_pkg::OP_ROTATE_RIGHT_CARRY_TO_WREG: begin
        result = rot_right_carry;
        to_wreg = 1'b1;
        upd_carry = 1'b1;
        new_carry = mem_rdata[0];
      end
      rss_pkg::OP_MINUS_WITH_BORROW, rss_pkg::OP_MINUS, rss_pkg::OP_MINUS_IMMEDIATE: begin
        result = sub_sum;
        to_wreg = 1'b1;
        upd_arith = 1'b1;
      end
      rss_pkg::OP_MINUS_BORROW_TO_MEMORY, rss_pkg::OP_MINUS_TO_MEMORY: begin
        result = sub_sum;
        to_mem = 1'b1;
        upd_arith = 1'b1;
      end
      rss_pkg::OP_DECREMENT_SKIP_ZERO, rss_pkg::OP_INCREMENT_SKIP_ZERO: begin
        result = step_sum;
        to_mem = 1'b1;
        skip_cond = step_zero;
      end
      rss_pkg::OP_DECREMENT_SKIP_ZERO_TO_WREG, rss_pkg::OP_INCREMENT_SKIP_ZERO_TO_WREG: begin
        result = step_sum;
        to_wreg = 1'b1;
        skip_cond = step_zero;
      end
      rss_pkg::OP_SET_BYTE: begin
        result = rss_pkg::ALL_ONES;
        to_mem = 1'b1;
      end
      rss_pkg::OP_SET_BIT: begin
        result = bit_forced;
        to_mem = 1'b1;
      end
      rss_pkg::OP_BIT_SET_SKIP: begin
        skip_cond = bit_chosen;
      end
      rss_pkg::OP_NIBBLE_EXCHANGE: begin
        result = nibble_swapped;
        to_mem = 1'b1;
      end
      rss_pkg::OP_NIBBLE_EXCHANGE_TO_WREG: begin
        result = nibble_swapped;
        to_wreg = 1'b1;
      end
      rss_pkg::OP_NONE: begin
        result = mem_rdata;
      end
      default: begin
        result = mem_rdata;
      end
    endcase
  end

  // Register port decode
  wire wr_wreg = clk_en && reg_wr && (reg_addr == rss_pkg::REG_WREG);
  wire wr_status = clk_en && reg_wr && (reg_addr == rss_pkg::REG_STATUS);
  wire op_wreg = op_take && to_wreg;
  wire op_carry = op_take && (upd_carry || upd_arith);
  wire op_arith = op_take && upd_arith;
  // Qualified strobes shared by the sequencing and counter blocks
  wire mem_take = op_take && to_mem;
  wire skip_take = op_take && skip_cond;

  // An operation retiring in the same cycle as a software write takes priority
  assign wreg_nxt = op_wreg ? result : (wr_wreg ? reg_wdata : wreg_r);
  // Adding the inverse leaves carry set exactly when no borrow occurred
  assign carry_nxt = op_carry ? (upd_arith ? sub_cout : new_carry)
                   : (wr_status ? reg_wdata[rss_pkg::ST_CARRY_BIT] : carry_r);
  assign half_carry_nxt = op_arith ? sub_hcout
                        : (wr_status ? reg_wdata[rss_pkg::ST_HALF_CARRY_BIT] : half_carry_r);
  assign zero_nxt = op_arith ? sub_zero
                  : (wr_status ? reg_wdata[rss_pkg::ST_ZERO_BIT] : zero_r);
  assign signed_wrap_nxt = op_arith ? sub_ovf
                         : (wr_status ? reg_wdata[rss_pkg::ST_SIGNED_WRAP_BIT] : signed_wrap_r);

  // Skip takes the dummy cycle; otherwise the next operation follows at once
  assign state_nxt = skip_take ? rss_pkg::ST_DUMMY : rss_pkg::ST_EXECUTE;

  // Read mux; unmapped bits read as zero
  wire rd_wreg = (reg_addr == rss_pkg::REG_WREG);
  wire rd_status = (reg_addr == rss_pkg::REG_STATUS);
  wire rd_skip_count = (reg_addr == rss_pkg::REG_SKIP_COUNT);
  wire [DATA_W-1:0] status_word = {{(DATA_W-rss_pkg::ST_USED_W){1'b0}},
                                   signed_wrap_r, zero_r, half_carry_r, carry_r};
  assign reg_rdata_nxt = !reg_rd ? rss_pkg::ALL_ZEROS
                       : rd_wreg ? wreg_r
                       : rd_status ? status_word
                       : rd_skip_count ? skip_count_r
                       : last_result_r;

  // Sequencing and write back
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= rss_pkg::ST_EXECUTE;
      ready_r <= 1'b1;
      skip_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_wdata_r <= rss_pkg::RESULT_RST;
      last_result_r <= rss_pkg::RESULT_RST;
    end else if (clk_en) begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == rss_pkg::ST_EXECUTE);
      skip_r <= skip_take;
      mem_we_r <= mem_take;
      if (mem_take) begin
        mem_wdata_r <= result;
      end
      if (op_take) begin
        last_result_r <= result;
      end
    end
  end

  // Skip statistics for software; the count wraps silently at its width
  // and is not cleared by reading, so software must take differences
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_count_r <= rss_pkg::SKIP_COUNT_RST;
    end else if (clk_en && skip_take) begin
      skip_count_r <= skip_count_r + 1'b1;
    end
  end

  // Architectural working register and flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wreg_r <= rss_pkg::WREG_RST;
      carry_r <= rss_pkg::FLAG_RST;
      half_carry_r <= rss_pkg::FLAG_RST;
      zero_r <= rss_pkg::FLAG_RST;
      signed_wrap_r <= rss_pkg::FLAG_RST;
    end else if (clk_en) begin
      wreg_r <= wreg_nxt;
      carry_r <= carry_nxt;
      half_carry_r <= half_carry_nxt;
      zero_r <= zero_nxt;
      signed_wrap_r <= signed_wrap_nxt;
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= rss_pkg::ALL_ZEROS;
    end else if (clk_en) begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  assign op_ready = ready_r;
  assign mem_we = mem_we_r;
  assign mem_wdata = mem_wdata_r;
  assign skip_pulse = skip_r;
  assign working_register = wreg_r;
  assign carry_flag = carry_r;
  assign half_carry_flag = half_carry_r;
  assign zero_flag = zero_r;
  assign signed_wrap_flag = signed_wrap_r;
  assign reg_rdata = reg_rdata_r;

endmodule

//--- tb/rss_datapath_properties.sv
// Concurrent checks on the ports of the rotate, subtract and skip datapath.
// Assumes one clock domain; bound to every rss_datapath instance below.
`timescale 1ns/100ps
module rss_datapath_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Operation issue
  input wire logic clk_en,
  input wire logic op_valid,
  input wire rss_pkg::rss_op_type op_code,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] imm_data,
  input wire logic [7:0] mem_rdata,
  input wire logic reg_wr,
  // Results
  input wire logic op_ready,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic skip_pulse,
  input wire logic [7:0] working_register,
  input wire logic carry_flag,
  input wire logic half_carry_flag,
  input wire logic zero_flag,
  input wire logic signed_wrap_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic tk;
  wire logic [3:0] fl;
  assign tk = clk_en && op_valid && op_ready;
  assign fl = {signed_wrap_flag, zero_flag, half_carry_flag, carry_flag};

  // A skip is one pulse during exactly one dummy cycle, then ready again
  sequence s_dummy;
    skip_pulse && !op_ready ##1 op_ready && !skip_pulse;
  endsequence

  property p_rlc;
    tk && op_code == rss_pkg::OP_ROTATE_LEFT_THROUGH_CARRY |=> mem_we &&
      mem_wdata == {$past(mem_rdata[6:0]), $past(carry_flag)} && carry_flag == $past(mem_rdata[7]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left through carry wrong");
  // A software write to status in the same cycle would legally move the flags
  property p_rr;
    tk && !reg_wr && op_code == rss_pkg::OP_ROTATE_RIGHT_PLAIN |=> mem_we &&
      mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(fl);
  endproperty
  a_rr: assert property (p_rr) else $error("plain rotate right wrong");
  property p_sbc;
    tk && op_code == rss_pkg::OP_MINUS_WITH_BORROW |=> working_register ==
      8'($past(working_register) + ~$past(mem_rdata) + $past(carry_flag));
  endproperty
  a_sbc: assert property (p_sbc) else $error("subtract with borrow wrong");
  property p_subi;
    tk && op_code == rss_pkg::OP_MINUS_IMMEDIATE |=>
      carry_flag == ($past(working_register) >= $past(imm_data)) &&
      zero_flag == ($past(working_register) == $past(imm_data));
  endproperty
  a_subi: assert property (p_subi) else $error("immediate subtract flags wrong");
  property p_dec;
    tk && op_code == rss_pkg::OP_DECREMENT_SKIP_ZERO && mem_rdata == 8'h01 |=>
      (mem_we && mem_wdata == 8'h00) ##0 s_dummy;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement skip wrong");
  property p_inc;
    tk && op_code == rss_pkg::OP_INCREMENT_SKIP_ZERO && mem_rdata != 8'hFF |=>
      op_ready && !skip_pulse && mem_wdata == 8'($past(mem_rdata) + 8'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("increment without skip wrong");
  property p_bss;
    tk && op_code == rss_pkg::OP_BIT_SET_SKIP |=>
      !mem_we && skip_pulse == $past(mem_rdata[bit_sel]);
  endproperty
  a_bss: assert property (p_bss) else $error("bit test skip wrong");
  property p_set;
    tk && op_code == rss_pkg::OP_SET_BYTE |=> mem_we && mem_wdata == 8'hFF;
  endproperty
  a_set: assert property (p_set) else $error("set byte wrong");
  property p_swpa;
    tk && op_code == rss_pkg::OP_NIBBLE_EXCHANGE_TO_WREG |=> !mem_we &&
      working_register == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])};
  endproperty
  a_swpa: assert property (p_swpa) else $error("nibble swap to wreg wrong");
endmodule

bind rss_datapath rss_datapath_checker u_chk (
  .sys_clk, .rst_n, .clk_en, .op_valid, .op_code, .bit_sel, .imm_data, .mem_rdata,
  .reg_wr, .op_ready, .mem_we, .mem_wdata, .skip_pulse, .working_register,
  .carry_flag, .half_carry_flag, .zero_flag, .signed_wrap_flag
);

//--- tb/rss_datapath_tb.sv
// Self-checking bench for the rotate, subtract and skip datapath.
// Drives the operation and register ports directly; no far-side model.
`timescale 1ns/100ps
module rss_datapath_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, op_valid = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  rss_pkg::rss_op_type op_code = rss_pkg::OP_NONE;
  logic [2:0] bit_sel = 3'h0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] imm_data = 8'h00, mem_rdata = 8'h00, reg_wdata = 8'h00, wexp = 8'h00, v;
  logic op_ready, mem_we, skip_pulse, carry_flag, half_carry_flag, zero_flag, signed_wrap_flag;
  logic [7:0] mem_wdata, working_register, reg_rdata;
  int error_cnt = 0, comparisons = 0, skips = 0;

  rss_datapath dut (.sys_clk, .rst_n, .clk_en, .op_valid, .op_code, .bit_sel, .imm_data,
    .mem_rdata, .op_ready, .mem_we, .mem_wdata, .skip_pulse, .working_register, .carry_flag,
    .half_carry_flag, .zero_flag, .signed_wrap_flag, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (a == rss_pkg::REG_WREG) wexp = d;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Kind k: 0 result to memory, 1 result to wreg, 2 no result
  task automatic run(input rss_pkg::rss_op_type c, input logic [7:0] m, input logic [7:0] im,
      input logic [7:0] r, input logic [2:0] bs, input int k, input logic sk);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= c;
    mem_rdata <= m;
    imm_data <= im;
    bit_sel <= bs;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    if (k == 1) wexp = r;
    chk(8'(mem_we), 8'(k == 0));
    if (k == 0) chk(mem_wdata, r);
    chk(working_register, wexp);
    chk(8'(skip_pulse), 8'(sk));
    chk(8'(op_ready), 8'(!sk));
    skips += int'(sk);
  endtask

  function automatic logic [11:0] sub(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~b} + 9'(ci);
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
    return {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), v);
      chk(v, 8'h00);
    end
    wr(rss_pkg::REG_STATUS, 8'hFF);
    rd(rss_pkg::REG_STATUS, v);
    chk(v, 8'h0F);
    wr(rss_pkg::REG_WREG, 8'hA5);
    rd(rss_pkg::REG_WREG, v);
    chk(v, 8'hA5);
    $display("register test done");
  endtask

  task automatic t_rot();
    wr(rss_pkg::REG_STATUS, 8'h0E);
    run(rss_pkg::OP_ROTATE_LEFT_THROUGH_CARRY, 8'h81, 8'h00, 8'h02, 3'h0, 0, 1'b0);
    chk(8'(carry_flag), 8'h01);
    run(rss_pkg::OP_ROTATE_RIGHT_PLAIN, 8'h01, 8'h00, 8'h80, 3'h0, 0, 1'b0);
    chk(8'(carry_flag), 8'h01);
    run(rss_pkg::OP_ROTATE_RIGHT_TO_WREG, 8'h02, 8'h00, 8'h01, 3'h0, 1, 1'b0);
    chk(8'(carry_flag), 8'h01);
    run(rss_pkg::OP_ROTATE_LEFT_CARRY_TO_WREG, 8'h01, 8'h00, 8'h03, 3'h0, 1, 1'b0);
    chk(8'(carry_flag), 8'h00);
    run(rss_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h01, 8'h00, 8'h00, 3'h0, 0, 1'b0);
    chk(8'(carry_flag), 8'h01);
    run(rss_pkg::OP_ROTATE_RIGHT_CARRY_TO_WREG, 8'h02, 8'h00, 8'h81, 3'h0, 1, 1'b0);
    rd(rss_pkg::REG_STATUS, v);
    chk(v, 8'h0E);
    $display("rotate test done");
  endtask

  // Non-borrow forms get carry cleared first, so a wrong carry-in shows up
  task automatic sub1(input rss_pkg::rss_op_type c, input logic [7:0] a, input logic [7:0] b,
      input logic ci, input int k);
    logic [11:0] e;
    e = sub(a, b, ci | !(c inside {rss_pkg::OP_MINUS_WITH_BORROW,
      rss_pkg::OP_MINUS_BORROW_TO_MEMORY}));
    wr(rss_pkg::REG_WREG, a);
    wr(rss_pkg::REG_STATUS, 8'(ci));
    if (c == rss_pkg::OP_MINUS_IMMEDIATE)
      run(c, ~b, b, e[7:0], 3'h0, k, 1'b0);
    else
      run(c, b, ~b, e[7:0], 3'h0, k, 1'b0);
    chk({4'h0, signed_wrap_flag, zero_flag, half_carry_flag, carry_flag}, {4'h0, e[11:8]});
    rd(rss_pkg::REG_STATUS, v);
    chk(v, {4'h0, e[11:8]});
  endtask

  task automatic t_sub();
    sub1(rss_pkg::OP_MINUS, 8'h10, 8'h20, 1'b0, 1);
    sub1(rss_pkg::OP_MINUS_TO_MEMORY, 8'h80, 8'h01, 1'b0, 0);
    sub1(rss_pkg::OP_MINUS_IMMEDIATE, 8'h05, 8'h05, 1'b0, 1);
    sub1(rss_pkg::OP_MINUS_WITH_BORROW, 8'h05, 8'h05, 1'b0, 1);
    sub1(rss_pkg::OP_MINUS_WITH_BORROW, 8'h37, 8'h12, 1'b1, 1);
    sub1(rss_pkg::OP_MINUS_BORROW_TO_MEMORY, 8'h7F, 8'hFF, 1'b1, 0);
    $display("subtract test done");
  endtask

  task automatic t_skip();
    wr(rss_pkg::REG_STATUS, 8'h05);
    run(rss_pkg::OP_DECREMENT_SKIP_ZERO, 8'h01, 8'h00, 8'h00, 3'h0, 0, 1'b1);
    run(rss_pkg::OP_DECREMENT_SKIP_ZERO, 8'h00, 8'h00, 8'hFF, 3'h0, 0, 1'b0);
    run(rss_pkg::OP_DECREMENT_SKIP_ZERO_TO_WREG, 8'h01, 8'h00, 8'h00, 3'h0, 1, 1'b1);
    run(rss_pkg::OP_INCREMENT_SKIP_ZERO, 8'hFF, 8'h00, 8'h00, 3'h0, 0, 1'b1);
    run(rss_pkg::OP_INCREMENT_SKIP_ZERO, 8'h41, 8'h00, 8'h42, 3'h0, 0, 1'b0);
    run(rss_pkg::OP_INCREMENT_SKIP_ZERO_TO_WREG, 8'h7F, 8'h00, 8'h80, 3'h0, 1, 1'b0);
    run(rss_pkg::OP_INCREMENT_SKIP_ZERO_TO_WREG, 8'hFF, 8'h00, 8'h00, 3'h0, 1, 1'b1);
    run(rss_pkg::OP_SET_BYTE, 8'h12, 8'h00, 8'hFF, 3'h0, 0, 1'b0);
    run(rss_pkg::OP_SET_BIT, 8'h00, 8'h00, 8'h80, 3'h7, 0, 1'b0);
    run(rss_pkg::OP_SET_BIT, 8'h5A, 8'h00, 8'h5B, 3'h0, 0, 1'b0);
    run(rss_pkg::OP_BIT_SET_SKIP, 8'h80, 8'h00, 8'h00, 3'h7, 2, 1'b1);
    run(rss_pkg::OP_BIT_SET_SKIP, 8'h7F, 8'h00, 8'h00, 3'h7, 2, 1'b0);
    run(rss_pkg::OP_NIBBLE_EXCHANGE, 8'hA5, 8'h00, 8'h5A, 3'h0, 0, 1'b0);
    run(rss_pkg::OP_NIBBLE_EXCHANGE_TO_WREG, 8'h3C, 8'h00, 8'hC3, 3'h0, 1, 1'b0);
    rd(rss_pkg::REG_STATUS, v);
    chk(v, 8'h05);
    rd(rss_pkg::REG_SKIP_COUNT, v);
    chk(v, 8'(skips));
    wr(rss_pkg::REG_LAST_RESULT, 8'h11);
    rd(rss_pkg::REG_LAST_RESULT, v);
    chk(v, 8'hC3);
    $display("skip test done");
  endtask

  // Clock enable low must freeze everything, even a request that would skip
  task automatic t_freeze();
    wr(rss_pkg::REG_WREG, 8'h3C);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    op_valid <= 1'b1;
    op_code <= rss_pkg::OP_DECREMENT_SKIP_ZERO_TO_WREG;
    mem_rdata <= 8'h01;
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    op_valid <= 1'b0;
    #1;
    chk(working_register, 8'h3C);
    chk({6'h00, mem_we, skip_pulse}, 8'h00);
    chk(8'(op_ready), 8'h01);
    run(rss_pkg::OP_NONE, 8'h5A, 8'h00, 8'h00, 3'h0, 2, 1'b0);
    $display("freeze test done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_rot();
    t_sub();
    t_skip();
    t_freeze();
    print_verdict();
  end

  // The tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    print_verdict();
  end
endmodule
